// [logic/spim_master.sv]
// Serial master top: register port, transfer sequencer, select logic and pin drivers.
// Assumes synchronous pins and a register master that never overlaps strobes.
//
// Implementation choices: the address map and the address-and-strobe port.
module spim_master
	import spim_pkg::*;
(
	input  wire logic                   core_clk_i, // 10 MHz core clock
	input  wire logic                   rst_i,      // Synchronous reset, active high
	input  wire logic [SPIM_ADDR_W-1:0] addr_i,     // Register byte address
	input  wire logic [31:0]            wr_data_i,  // Register write data
	input  wire logic                   wr_en_i,    // Write strobe
	input  wire logic                   rd_en_i,    // Read strobe
	output logic      [31:0]            rd_data_o,  // Read data, cycle after strobe
	output logic                        sck_o,      // Serial clock
	output logic                        sck_oe_n_o, // Serial clock drive, low drives
	output logic                        mosi_o,     // Outgoing data
	output logic                        mosi_oe_n_o,// Outgoing data drive, low drives
	input  wire logic                   miso_i,     // Incoming data
	output logic      [SPIM_NUM_SEL-1:0] sel_n_o,   // Slave selects, active low
	output logic      [SPIM_NUM_SEL-1:0] sel_oe_n_o,// Select drive, low drives
	output logic                        busy_o,     // Transfer in progress
	output logic                        irq_o       // Completion interrupt, level
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	spim_state_t            state_ff;
	spim_state_t            nxt_state;
	logic                   enabled_ff;
	logic                   nxt_enabled;
	logic [1:0]             count_ff;
	logic                   lsb_ff;
	logic                   inv_ff;
	logic                   trail_ff;
	logic                   irq_en_ff;
	logic                   auto_ff;
	logic                   dly_ff;
	logic [5:0]             div_ff;
	logic [SPIM_NUM_SEL-1:0] mask_ff;
	logic [SPIM_NUM_SEL-1:0] nxt_mask;
	logic [SPIM_NUM_SEL-1:0] sel_valid;
	logic [SPIM_NUM_SEL-1:0] sel_n_ff;
	logic [SPIM_NUM_SEL-1:0] sel_oe_n_ff;
	logic                   sel_on;
	logic [4:0]             len_ff;
	logic [4:0]             run_len_ff;
	logic [31:0]            rx_data_ff;
	logic [31:0]            rd_data_ff;
	logic [31:0]            rd_mux;
	logic [6:0]             half_ff;
	logic [6:0]             two_len;
	logic [6:0]             last_half;
	logic                   run_now;
	logic                   tick;
	logic                   toggle;
	logic                   fin;
	logic                   sck_ff;
	logic                   sck_oe_n_ff;
	logic                   mosi_oe_n_ff;
	logic                   busy_ff;
	logic                   done_ff;
	logic                   nxt_done;
	logic                   irq_ff;
	logic                   cfg_wr;
	logic                   sel_wr;
	logic                   len_wr;
	logic                   tx_wr;
	logic                   stat_wr;
	logic                   ctrl_wr;
	logic                   start;
	logic [6:0]             edge_cnt_ff;
	logic [5:0]             samp_cnt_ff;

	spim_shift_if sh ();

	// ****************************************************************
	// Register writes
	// ****************************************************************
	assign cfg_wr  = wr_en_i && (addr_i == SPIM_REG_CONFIG);
	assign sel_wr  = wr_en_i && (addr_i == SPIM_REG_SELECT);
	assign len_wr  = wr_en_i && (addr_i == SPIM_REG_LENGTH);
	assign tx_wr   = wr_en_i && (addr_i == SPIM_REG_TXDATA);
	assign stat_wr = wr_en_i && (addr_i == SPIM_REG_STATUS);
	assign ctrl_wr = wr_en_i && (addr_i == SPIM_REG_CONTROL);
	// Data written while busy or disabled is dropped, so a running word is never corrupted
	assign start   = tx_wr && enabled_ff && (state_ff == SPIM_IDLE);

	always_comb begin
		nxt_enabled = enabled_ff;
		if (cfg_wr) begin
			nxt_enabled = 1'b1;
		end else if (ctrl_wr && wr_data_i[SPIM_CTRL_DISABLE]) begin
			nxt_enabled = 1'b0;
		end
	end

	always_comb begin
		nxt_mask = mask_ff;
		if (sel_wr) begin
			nxt_mask = wr_data_i[SPIM_NUM_SEL-1:0];
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			enabled_ff <= 1'b0;
			count_ff   <= SPIM_RST_COUNT;
			lsb_ff     <= 1'b0;
			inv_ff     <= 1'b0;
			trail_ff   <= 1'b0;
			div_ff     <= SPIM_RST_DIV;
			irq_en_ff  <= 1'b0;
			auto_ff    <= 1'b0;
			dly_ff     <= 1'b0;
			mask_ff    <= SPIM_RST_MASK;
			len_ff     <= SPIM_RST_LEN;
		end else begin
			enabled_ff <= nxt_enabled;
			mask_ff    <= nxt_mask;
			if (cfg_wr) begin
				if (wr_data_i[SPIM_CFG_COUNT +: 8] > SPIM_COUNT_LIMIT) begin
					count_ff <= SPIM_COUNT_MAX;
				end else begin
					count_ff <= wr_data_i[SPIM_CFG_COUNT +: 2];
				end
				lsb_ff    <= wr_data_i[SPIM_CFG_LSB];
				inv_ff    <= wr_data_i[SPIM_CFG_INVERT];
				trail_ff  <= wr_data_i[SPIM_CFG_TRAIL];
				div_ff    <= wr_data_i[SPIM_CFG_DIV +: 6];
				irq_en_ff <= wr_data_i[SPIM_CFG_IRQ_EN];
				auto_ff   <= wr_data_i[SPIM_CFG_AUTO];
				dly_ff    <= wr_data_i[SPIM_CFG_DELAY];
			end
			if (len_wr) begin
				len_ff <= wr_data_i[4:0];
			end
		end
	end

	// ****************************************************************
	// Register reads
	// ****************************************************************
	always_comb begin
		rd_mux = '0;
		if (addr_i == SPIM_REG_CONFIG) begin
			rd_mux[SPIM_CFG_COUNT +: 2] = count_ff;
			rd_mux[SPIM_CFG_LSB]        = lsb_ff;
			rd_mux[SPIM_CFG_INVERT]     = inv_ff;
			rd_mux[SPIM_CFG_TRAIL]      = trail_ff;
			rd_mux[SPIM_CFG_DIV +: 6]   = div_ff;
			rd_mux[SPIM_CFG_IRQ_EN]     = irq_en_ff;
			rd_mux[SPIM_CFG_AUTO]       = auto_ff;
			rd_mux[SPIM_CFG_DELAY]      = dly_ff;
		end else if (addr_i == SPIM_REG_SELECT) begin
			rd_mux[SPIM_NUM_SEL-1:0] = mask_ff;
		end else if (addr_i == SPIM_REG_LENGTH) begin
			rd_mux[4:0] = len_ff;
		end else if (addr_i == SPIM_REG_RXDATA) begin
			rd_mux = rx_data_ff;
		end else if (addr_i == SPIM_REG_STATUS) begin
			rd_mux[SPIM_STAT_BUSY]    = busy_ff;
			rd_mux[SPIM_STAT_DONE]    = done_ff;
			rd_mux[SPIM_STAT_ENABLED] = enabled_ff;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i || !rd_en_i) begin
			rd_data_ff <= '0;
		end else begin
			rd_data_ff <= rd_mux;
		end
	end

	// ****************************************************************
	// Transfer sequencer
	// ****************************************************************
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			SPIM_IDLE: begin
				if (start) begin
					nxt_state = SPIM_RUN;
				end
			end
			SPIM_RUN: begin
				if (fin) begin
					nxt_state = SPIM_DONE;
				end
			end
			default: begin
				nxt_state = SPIM_IDLE;
			end
		endcase
		// Disable aborts a running word without a completion
		if (!nxt_enabled) begin
			nxt_state = SPIM_IDLE;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			state_ff   <= SPIM_IDLE;
			half_ff    <= '0;
			run_len_ff <= SPIM_RST_LEN;
		end else begin
			state_ff <= nxt_state;
			if (start) begin
				half_ff    <= '0;
				run_len_ff <= len_ff;
			end else if (run_now && tick) begin
				half_ff <= half_ff + 7'h01;
			end
		end
	end

	spim_clk_div #(
		.DIV_W      (6)
	) u_div (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.clear_i    (!run_now),
		.divisor_i  (div_ff),
		.tick_o     (tick)
	);

	// Half periods are numbered from 0; a word of L bits spans 2L clock edges
	assign run_now   = (state_ff == SPIM_RUN);
	assign two_len   = {1'b0, run_len_ff, 1'b0} + 7'h02;
	// Late capture in trailing mode needs one extra half period after the last edge
	assign last_half = two_len - 7'h01 + {6'h00, trail_ff & dly_ff};
	assign toggle    = run_now && tick && (half_ff < two_len);
	assign fin       = run_now && tick && (half_ff == last_half);

	assign sh.load      = start;
	assign sh.lsb_first = lsb_ff;
	assign sh.len_code  = start ? len_ff : run_len_ff;
	assign sh.tx_word   = wr_data_i;
	assign sh.miso      = miso_i;
	assign sh.sample    = run_now && tick && (half_ff[0] == (trail_ff ^ dly_ff))
	                      && !(trail_ff && dly_ff && (half_ff == 7'h00));
	assign sh.launch    = run_now && tick && (half_ff[0] != trail_ff) && (half_ff != 7'h00)
	                      && (half_ff < two_len - 7'h01);

	spim_shifter u_shift (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.sh_io      (sh)
	);

	// ****************************************************************
	// Pins, status and completion
	// ****************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < SPIM_NUM_SEL; gi++) begin : g_sel
			assign sel_valid[gi] = (2'(gi) <= count_ff);
		end
	endgenerate

	assign sel_on = nxt_enabled && (!auto_ff || (nxt_state != SPIM_IDLE));

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			sck_ff       <= 1'b0;
			sck_oe_n_ff  <= 1'b1;
			mosi_oe_n_ff <= 1'b1;
			sel_n_ff     <= '1;
			sel_oe_n_ff  <= '1;
			busy_ff      <= 1'b0;
		end else begin
			sck_oe_n_ff  <= !nxt_enabled;
			mosi_oe_n_ff <= !nxt_enabled;
			sel_oe_n_ff  <= nxt_enabled ? ~sel_valid : '1;
			sel_n_ff     <= ~(nxt_mask & sel_valid & {SPIM_NUM_SEL{sel_on}});
			busy_ff      <= (nxt_state != SPIM_IDLE);
			if (!run_now) begin
				sck_ff <= inv_ff;
			end else if (toggle) begin
				sck_ff <= !sck_ff;
			end
		end
	end

	// A completion landing on a clearing write still sets the flag
	assign nxt_done = (state_ff == SPIM_DONE)
	                  || (done_ff && !(stat_wr && wr_data_i[SPIM_STAT_DONE]));

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			done_ff    <= 1'b0;
			irq_ff     <= 1'b0;
			rx_data_ff <= '0;
		end else begin
			done_ff <= nxt_done;
			irq_ff  <= nxt_done && irq_en_ff;
			if (state_ff == SPIM_DONE) begin
				rx_data_ff <= sh.rx_word;
			end
		end
	end

	assign rd_data_o   = rd_data_ff;
	assign sck_o       = sck_ff;
	assign sck_oe_n_o  = sck_oe_n_ff;
	assign mosi_o      = sh.out_bit;
	assign mosi_oe_n_o = mosi_oe_n_ff;
	assign sel_n_o     = sel_n_ff;
	assign sel_oe_n_o  = sel_oe_n_ff;
	assign busy_o      = busy_ff;
	assign irq_o       = irq_ff;

	// ****************************************************************
	// Checks
	// ****************************************************************
	always_ff @(posedge core_clk_i) begin
		if (rst_i || start) begin
			edge_cnt_ff <= '0;
			samp_cnt_ff <= '0;
		end else begin
			if (toggle) begin
				edge_cnt_ff <= edge_cnt_ff + 7'h01;
			end
			if (sh.sample) begin
				samp_cnt_ff <= samp_cnt_ff + 6'h01;
			end
		end
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	sequence s_start;
		start;
	endsequence
	sequence s_finish;
		fin;
	endsequence

	property p_reset_quiet;
		$fell(rst_i) |-> sck_oe_n_o && mosi_oe_n_o && (&sel_oe_n_o) && !busy_o && !irq_o;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("pins driven after reset");

	property p_cfg_enable;
		cfg_wr |=> enabled_ff && !sck_oe_n_o && !mosi_oe_n_o;
	endproperty
	a_cfg_enable: assert property (p_cfg_enable) else $error("config write did not enable");

	property p_count_sat;
		cfg_wr && (wr_data_i[SPIM_CFG_COUNT +: 8] > SPIM_COUNT_LIMIT) |=> count_ff == SPIM_COUNT_MAX;
	endproperty
	a_count_sat: assert property (p_count_sat) else $error("slave count not saturated");

	property p_mask_width;
		$stable(count_ff) |-> ((count_ff >= 2'h2) || sel_n_o[2])
		                      && ((count_ff != SPIM_RST_COUNT) || sel_n_o[1]);
	endproperty
	a_mask_width: assert property (p_mask_width) else $error("select beyond slave count");

	property p_auto_assert;
		s_start ##0 auto_ff |=> sel_n_o == ~(mask_ff & sel_valid);
	endproperty
	a_auto_assert: assert property (p_auto_assert) else $error("auto select missing");

	property p_auto_release;
		s_finish ##1 auto_ff |=> (&sel_n_o);
	endproperty
	a_auto_release: assert property (p_auto_release) else $error("auto select held");

	property p_manual;
		!auto_ff && enabled_ff && $stable(auto_ff) && $stable(enabled_ff) && $stable(count_ff)
		|-> sel_n_o == ~(mask_ff & sel_valid);
	endproperty
	a_manual: assert property (p_manual) else $error("manual select not following mask");

	property p_idle_level;
		!run_now && !$past(run_now) && $stable(inv_ff) |-> (sck_o == inv_ff);
	endproperty
	a_idle_level: assert property (p_idle_level) else $error("clock off idle level");

	property p_transfer_len;
		s_finish |=> (edge_cnt_ff == two_len) && (samp_cnt_ff == {1'b0, run_len_ff} + 6'h01);
	endproperty
	a_transfer_len: assert property (p_transfer_len) else $error("bit count mismatch");

	property p_busy_span;
		s_finish |=> busy_o ##1 !busy_o;
	endproperty
	a_busy_span: assert property (p_busy_span) else $error("busy not spanning transfer");

	property p_irq_on;
		(state_ff == SPIM_DONE) && irq_en_ff |=> irq_o;
	endproperty
	a_irq_on: assert property (p_irq_on) else $error("completion interrupt missing");

	property p_irq_off;
		!$past(irq_en_ff) |-> !irq_o;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("interrupt while disabled");

	property p_sample_edge;
		sh.sample && !dly_ff |-> ((sck_o == inv_ff) != trail_ff);
	endproperty
	a_sample_edge: assert property (p_sample_edge) else $error("capture on wrong edge");

endmodule : spim_master

// [logic/spim_pkg.sv]
// Shared constants of the serial master: register map, field layout, reset values, states.
// Assumes a single core clock and a word-spaced register port with byte addresses.
package spim_pkg;

	// ****************************************************************
	// Register map and fields
	// ****************************************************************
	localparam int unsigned     SPIM_ADDR_W       = 5;
	localparam int unsigned     SPIM_NUM_SEL      = 3;
	localparam logic [4:0]      SPIM_REG_CONFIG   = 5'h00;
	localparam logic [4:0]      SPIM_REG_SELECT   = 5'h04;
	localparam logic [4:0]      SPIM_REG_LENGTH   = 5'h08;
	localparam logic [4:0]      SPIM_REG_TXDATA   = 5'h0c;
	localparam logic [4:0]      SPIM_REG_RXDATA   = 5'h10;
	localparam logic [4:0]      SPIM_REG_STATUS   = 5'h14;
	localparam logic [4:0]      SPIM_REG_CONTROL  = 5'h18;

	localparam int unsigned     SPIM_CFG_COUNT    = 0;
	localparam int unsigned     SPIM_CFG_LSB      = 8;
	localparam int unsigned     SPIM_CFG_INVERT   = 9;
	localparam int unsigned     SPIM_CFG_TRAIL    = 10;
	localparam int unsigned     SPIM_CFG_DIV      = 11;
	localparam int unsigned     SPIM_CFG_IRQ_EN   = 17;
	localparam int unsigned     SPIM_CFG_AUTO     = 18;
	localparam int unsigned     SPIM_CFG_DELAY    = 19;
	localparam int unsigned     SPIM_STAT_BUSY    = 0;
	localparam int unsigned     SPIM_STAT_DONE    = 1;
	localparam int unsigned     SPIM_STAT_ENABLED = 2;
	localparam int unsigned     SPIM_CTRL_DISABLE = 0;

	// ****************************************************************
	// Limits and reset values
	// ****************************************************************
	localparam logic [7:0]      SPIM_COUNT_LIMIT  = 8'h03;
	localparam logic [1:0]      SPIM_COUNT_MAX    = 2'h3;
	localparam logic [1:0]      SPIM_RST_COUNT    = 2'h0;
	localparam logic [5:0]      SPIM_RST_DIV      = 6'h00;
	localparam logic [4:0]      SPIM_RST_LEN      = 5'h07;
	localparam logic [2:0]      SPIM_RST_MASK     = 3'h0;

	typedef enum logic [1:0] {
		SPIM_IDLE,
		SPIM_RUN,
		SPIM_DONE
	} spim_state_t;

endpackage : spim_pkg

// [logic/spim_shift_if.sv]
// Bundle between the transfer sequencer and the shift engine.
// Assumes both ends run on the same core clock.
interface spim_shift_if;
	logic        load;
	logic        launch;
	logic        sample;
	logic        lsb_first;
	logic        miso;
	logic        out_bit;
	logic [4:0]  len_code;
	logic [31:0] tx_word;
	logic [31:0] rx_word;

	modport ctrl (output load, launch, sample, lsb_first, miso, len_code, tx_word,
	              input  out_bit, rx_word);
	modport engine (input  load, launch, sample, lsb_first, miso, len_code, tx_word,
	                output out_bit, rx_word);
endinterface : spim_shift_if

// [logic/spim_clk_div.sv]
// Half-period enable for the serial clock: one tick every max(divisor,1) core cycles.
// Assumes clear_i is held while no transfer runs, so each transfer starts a fresh count.
module spim_clk_div #(
	parameter int unsigned DIV_W = 6
) (
	input  wire logic             core_clk_i, // Core clock
	input  wire logic             rst_i,      // Synchronous reset, active high
	input  wire logic             clear_i,    // Hold counter at zero
	input  wire logic [DIV_W-1:0] divisor_i,  // Half period in core cycles
	output logic                  tick_o      // One-cycle half-period pulse
);
	logic [DIV_W-1:0] cnt_ff;

	always_ff @(posedge core_clk_i) begin
		if (rst_i || clear_i) begin
			cnt_ff <= '0;
			tick_o <= 1'b0;
		end else if (cnt_ff + 1'b1 >= divisor_i) begin
			cnt_ff <= '0;
			tick_o <= 1'b1;
		end else begin
			cnt_ff <= cnt_ff + 1'b1;
			tick_o <= 1'b0;
		end
	end

	property p_div_gap;
		@(posedge core_clk_i) disable iff (rst_i)
		tick_o && (divisor_i > 2) && $stable(divisor_i) && !clear_i |=> !tick_o ##1 !tick_o;
	endproperty
	a_div_gap: assert property (p_div_gap) else $error("tick spacing below divisor");
endmodule : spim_clk_div

// [logic/spim_shifter.sv]
// Shift engine: parallel load, bit-serial launch and capture, right-aligned result.
// Assumes load, launch and sample are one-cycle strobes from the sequencer.
module spim_shifter (
	input  wire logic    core_clk_i, // Core clock
	input  wire logic    rst_i,      // Synchronous reset, active high
	spim_shift_if.engine sh_io       // Sequencer side
);
	logic [31:0] tx_ff;
	logic [31:0] nxt_tx;
	logic [31:0] rx_ff;
	logic [4:0]  shamt;

	// Unused upper bits of the word are pushed out or ignored by this shift
	assign shamt = 5'h1f - sh_io.len_code;

	always_comb begin
		nxt_tx = tx_ff;
		if (sh_io.load) begin
			nxt_tx = sh_io.lsb_first ? sh_io.tx_word : (sh_io.tx_word << shamt);
		end else if (sh_io.launch) begin
			nxt_tx = sh_io.lsb_first ? (tx_ff >> 1) : (tx_ff << 1);
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			tx_ff          <= '0;
			sh_io.out_bit  <= 1'b0;
		end else begin
			tx_ff          <= nxt_tx;
			sh_io.out_bit  <= sh_io.lsb_first ? nxt_tx[0] : nxt_tx[31];
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i || sh_io.load) begin
			rx_ff <= '0;
		end else if (sh_io.sample) begin
			rx_ff <= sh_io.lsb_first ? {sh_io.miso, rx_ff[31:1]} : {rx_ff[30:0], sh_io.miso};
		end
	end

	assign sh_io.rx_word = sh_io.lsb_first ? (rx_ff >> shamt) : rx_ff;

	property p_first_bit;
		@(posedge core_clk_i) disable iff (rst_i)
		sh_io.load && sh_io.lsb_first |=> sh_io.out_bit == $past(sh_io.tx_word[0]);
	endproperty
	a_first_bit: assert property (p_first_bit) else $error("first low bit not driven");
endmodule : spim_shifter

// [dv/spim_slave_model.sv]
// Behavioural slave on one select line: sends tx_i, collects what it latches.
// Assumes the bench sets mode, order and length before the select falls.
module spim_slave_model (
	input  wire logic        core_clk_i, // Core clock
	input  wire logic        sck_i,      // Serial clock
	input  wire logic        mosi_i,     // Master data
	input  wire logic        sel_n_i,    // Select, low active
	input  wire logic        cpol_i,     // Clock invert
	input  wire logic        cpha_i,     // Trailing edge latch
	input  wire logic        lsb_i,      // Low bit first
	input  wire logic [5:0]  len_i,      // Bits per word
	input  wire logic [31:0] tx_i,       // Word to send
	output logic             miso_o,     // Slave data
	output logic      [31:0] rx_o        // Word latched
);
	timeunit 1ns;
	timeprecision 1ns;
	logic drv = 1'b0;
	logic mq  = 1'b0;
	int   no  = 0;
	int   ni  = 0;
	// ****************
	// Link behaviour
	// ****************
	// Released line shows the inverse so a stale bit never passes
	assign miso_o = sel_n_i ? ~drv : drv;
	// Value before the edge: sck and mosi move in the same time step
	always @(negedge core_clk_i) mq = mosi_i;
	function automatic logic pick(input int k);
		if (k >= int'(len_i))
			return drv;
		return lsb_i ? tx_i[k] : tx_i[int'(len_i) - 1 - k];
	endfunction : pick
	always @(negedge sel_n_i) begin
		rx_o = '0;
		ni = 0;
		no = cpha_i ? 0 : 1;
		if (!cpha_i)
			drv = pick(0);
	end
	always @(sck_i) if (!sel_n_i) begin
		if ((sck_i != cpol_i) == cpha_i) begin
			drv = pick(no);
			no++;
		end else begin
			if (lsb_i)
				rx_o[ni] = mq;
			else
				rx_o = {rx_o[30:0], mq};
			ni++;
		end
	end
endmodule : spim_slave_model

// [dv/tb_spim_master.sv]
// Bench for the serial master: register tasks, slave model, queued read checks.
// Assumes the slave model sits on select line 0.
module tb_spim_master import spim_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        we = 1'b0;
	logic        re = 1'b0;
	logic        rd_seen = 1'b0;
	logic [4:0]  addr = '0;
	logic [31:0] wdat = '0;
	logic [31:0] stx = '0;
	logic [31:0] rdat, rx, tx, m, cfg;
	logic        sck, sck_oe_n, mosi, mosi_oe_n, miso, busy, irq, sck_d;
	logic [2:0]  sel_n, sel_oe_n;
	logic        cpol, cpha, lsb, ie, dly;
	logic [5:0]  len;
	int          n_mismatch, compares, n_edge, n_base, gap, hp, dv;
	logic [31:0] q[$];
	spim_master spim_master_i (.core_clk_i(clk), .rst_i(rst), .addr_i(addr),
		.wr_data_i(wdat), .wr_en_i(we), .rd_en_i(re), .rd_data_o(rdat), .sck_o(sck),
		.sck_oe_n_o(sck_oe_n), .mosi_o(mosi), .mosi_oe_n_o(mosi_oe_n), .miso_i(miso),
		.sel_n_o(sel_n), .sel_oe_n_o(sel_oe_n), .busy_o(busy), .irq_o(irq));
	spim_slave_model spim_slave_model_i (.core_clk_i(clk), .sck_i(sck), .mosi_i(mosi),
		.sel_n_i(sel_n[0]), .cpol_i(cpol), .cpha_i(cpha), .lsb_i(lsb), .len_i(len),
		.tx_i(stx), .miso_o(miso), .rx_o(rx));
	always #50 clk = ~clk;
	// ****************
	// Tasks
	// ****************
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdat <= d;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	endtask : wr
	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		re <= 1'b1;
		q.push_back(e);
		@(posedge clk);
		re <= 1'b0;
	endtask : rd
	task automatic conclude();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude
	// Read results and serial clock spacing
	always @(posedge clk) begin
		if (rd_seen)
			check(rdat, q.pop_front());
		rd_seen <= re;
		sck_d <= sck;
		gap <= gap + 1;
		if (sck !== sck_d) begin
			if (n_edge > n_base && busy === 1'b1)
				check(32'(gap), 32'(hp));
			n_edge <= n_edge + 1;
			gap <= 1;
		end
	end
	initial begin
		#2000000;
		n_mismatch++;
		conclude();
	end
	initial begin
		{cpol, cpha, lsb} = 3'h0;
		len = 6'h01;
		void'($urandom(32'h2c1a));
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		check(32'({sck_oe_n, mosi_oe_n, sel_oe_n, sel_n, busy, irq}), 32'h3fc);
		rd(SPIM_REG_STATUS, 32'h0);
		for (int c = 0; c < 4; c++) begin
			wr(SPIM_REG_CONFIG, (c == 3) ? 32'hff : 32'(c));
			wr(SPIM_REG_SELECT, 32'h7);
			@(posedge clk);
			#1;
			m = (c == 0) ? 32'h1 : (c == 1) ? 32'h3 : 32'h7;
			check(32'({sel_n, sel_oe_n}), 32'({~m[2:0], ~m[2:0]}));
			check(32'({sck_oe_n, mosi_oe_n, sck}), 32'h0);
			rd(SPIM_REG_CONFIG, (c == 3) ? 32'h3 : 32'(c));
		end
		for (int i = 0; i < 12; i++) begin
			{cpol, cpha} = 2'(i);
			{lsb, ie, dly} = 3'($urandom);
			dv = $urandom_range(3, 0);
			hp = (dv == 0) ? 1 : dv;
			len = (i == 0) ? 6'h01 : (i == 1) ? 6'h20 : 6'($urandom_range(32, 1));
			m = 32'hffffffff >> (32 - len);
			tx = $urandom;
			stx = $urandom;
			cfg = 32'({dly, 1'b1, ie, 6'(dv), cpha, cpol, lsb, 8'h03});
			wr(SPIM_REG_CONFIG, cfg);
			wr(SPIM_REG_SELECT, 32'h1);
			wr(SPIM_REG_LENGTH, 32'(len - 6'h01));
			rd(SPIM_REG_CONFIG, cfg);
			#1;
			check(32'(sck), 32'(cpol));
			n_base = n_edge;
			wr(SPIM_REG_TXDATA, tx);
			@(posedge clk);
			#1;
			check(32'({busy, sel_n}), 32'he);
			// Polled rather than interrupt driven, as fast links need
			for (int k = 0; k < 4000 && busy === 1'b1; k++)
				@(posedge clk);
			#1;
			check(32'({busy, sel_n, irq}), 32'({4'h7, ie}));
			check(rx, tx & m);
			rd(SPIM_REG_RXDATA, stx & m);
			rd(SPIM_REG_STATUS, 32'h6);
			wr(SPIM_REG_STATUS, 32'h2);
			repeat (2) @(posedge clk);
			#1;
			check(32'({irq, sck}), 32'(cpol));
			check(32'(n_edge - n_base), 32'(2 * len));
		end
		wr(SPIM_REG_CONTROL, 32'h1);
		@(posedge clk);
		#1;
		check(32'({sck_oe_n, mosi_oe_n, sel_oe_n}), 32'h1f);
		rd(5'h1c, 32'h0);
		repeat (3) @(posedge clk);
		conclude();
	end
endmodule : tb_spim_master
